// ---- logic/acps_slave.sv ----
// Purpose: amplifier control port, I2C slave with paged registers and power state
// Assumes: SCL and SDA asynchronous to clock; open drain, enable pulls low
// Notes:   only page 0 holds the registers below, in any book; other pages read zero but for the page register
//
// Behaviour
// - four phase positions, 45 degrees apart
// - 0x03/07/0B/0F enable sync, pick phase
// - host halts clocks, sets phase, hiz, restarts
// - resumed audio clocks trigger automatic phase alignment
// - powerdown low resets every register
// - host rewrites configuration after shutdown
// - state 00 deep sleep, analogue regulator off
// - state 01 sleep, analogue regulator kept
// - state 10 outputs high impedance only
// - state 11 play, outputs switching
// - two-bit field picks modulation scheme
// - in-phase-idle: legs in phase at idle
// - single-side: idle near 14 percent
// - hybrid: duty follows signal and supply setting
// - I2C slave, single and multi byte
// - register zero holds page number
// - seven bit address, prefix 01011
// - strap sets two low address bits
// - host reads with write, restart, read
// - ack both address phases, send data
// - host nacks last byte then stops
// - book register 0x7f on page zero
module acps_slave
  import acps_pkg::*;
(
  // system
  input  wire logic       clock,
  input  wire logic       nrst,
  // bus
  acps_if.slave           bus,
  // strap and audio clock presence
  input  wire logic [1:0] addr_strap,
  input  wire logic       audio_clk_present,
  // amplifier controls
  output logic      [1:0] output_modulation_select,
  output logic            analog_regulator_on,
  output logic            outputs_hiz,
  output logic            outputs_switching,
  output logic            phase_sync_enable,
  output logic      [1:0] phase_select,
  output logic            phase_aligning,
  output logic      [7:0] book_select
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } acps_st_t;

  acps_st_t st, next_st;
  logic [1:0] scl_s, sda_s, next_scl_s, next_sda_s;
  logic       scl_d, sda_d, next_scl_d, next_sda_d;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic       rd, next_rd, have_ptr, next_have_ptr, sda_oe, next_sda_oe;
  logic [7:0] ptr, next_ptr, page, next_page, book, next_book;
  logic [7:0] modr, next_modr, pwr, next_pwr, phs, next_phs;
  logic [1:0] strap, next_strap, strap_q;
  logic       clk_seen, next_clk_seen, aud_q1, aud_q2, next_aud_q1, next_aud_q2;
  logic [4:0] align_cnt, next_align_cnt;
  logic       start_c, stop_c, rise, fall;
  logic [7:0] rdata;

  // register read mux; only page zero is populated
  always_comb
  begin
    rdata = 8'h00;
    if (ptr == REG_PAGE_SELECT) rdata = page;
    else if (page == RST_PAGE)
    begin
      case (ptr)
        REG_MODULATION:  rdata = modr;
        REG_POWER_STATE: rdata = pwr;
        REG_PHASE_SYNC:  rdata = phs;
        REG_BOOK_SELECT: rdata = book;
        default:         rdata = 8'h00;
      endcase
    end
  end

  assign start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_c  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  assign rise    = scl_s[1] & ~scl_d;
  assign fall    = ~scl_s[1] & scl_d;

  // bus protocol and register writes
  always_comb
  begin
    next_scl_s = {scl_s[0], bus.scl};
    next_sda_s = {sda_s[0], bus.sda};
    next_scl_d = scl_s[1];
    next_sda_d = sda_s[1];
    next_st = st;
    next_bitn = bitn;
    next_sh = sh;
    next_rd = rd;
    next_have_ptr = have_ptr;
    next_sda_oe = sda_oe;
    next_ptr = ptr;
    next_page = page;
    next_book = book;
    next_modr = modr;
    next_pwr = pwr;
    next_phs = phs;
    next_strap = strap_q;                                 // second strap stage
    if (start_c)
    begin
      next_st = ST_ADDR;
      next_bitn = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_st = ST_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (st)
        ST_IDLE: next_sda_oe = 1'b0;
        ST_ADDR, ST_RX:
        begin
          // bits counted on rises, so the fall closing a start is ignored
          if (rise)
          begin
            next_sh = {sh[6:0], sda_s[1]};
            next_bitn = bitn + 4'h1;
          end
          if (fall && bitn == 4'h8)
          begin
            next_bitn = 4'h0;
            if (st == ST_ADDR)
            begin
              if (sh[7:1] == {ADDR_PREFIX, strap})
              begin
                next_rd = sh[0];
                next_have_ptr = 1'b0;
                next_sda_oe = 1'b1;
                next_st = ST_ACK;
              end
              else next_st = ST_IDLE;
            end
            else
            begin
              next_sda_oe = 1'b1;
              next_st = ST_ACK;
              if (!have_ptr)
              begin
                next_ptr = sh;
                next_have_ptr = 1'b1;
              end
              else
              begin
                if (ptr == REG_PAGE_SELECT) next_page = sh;
                else if (page == RST_PAGE)
                begin
                  case (ptr)
                    REG_MODULATION:  next_modr = sh;
                    REG_POWER_STATE: next_pwr = sh;
                    REG_PHASE_SYNC:  next_phs = sh;
                    REG_BOOK_SELECT: next_book = sh;
                    default:         next_ptr = ptr;
                  endcase
                end
                next_ptr = ptr + 8'h01;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (fall)
          begin
            next_bitn = 4'h0;
            if (rd)
            begin
              next_sh = rdata;
              next_sda_oe = ~rdata[7];
              next_st = ST_TX;
            end
            else
            begin
              next_sda_oe = 1'b0;
              next_st = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (fall && bitn == 4'h7)
          begin
            next_sda_oe = 1'b0;
            next_ptr = ptr + 8'h01;
            next_st = ST_MACK;
          end
          else if (fall)
          begin
            next_bitn = bitn + 4'h1;
            next_sh = {sh[6:0], 1'b0};
            next_sda_oe = ~sh[6];
          end
        end
        ST_MACK:
        begin
          if (rise && sda_s[1]) next_st = ST_IDLE;
          else if (rise)
          begin
            next_sh = rdata;
            next_st = ST_ACK;
          end
        end
        default: next_st = ST_IDLE;
      endcase
    end
  end

  // audio clock watch and automatic phase alignment
  always_comb
  begin
    next_aud_q1 = audio_clk_present;
    next_aud_q2 = aud_q1;
    next_clk_seen = aud_q2;
    next_align_cnt = align_cnt;
    if (aud_q2 && !clk_seen && phs[1:0] == PHASE_ENABLE_VAL)
      next_align_cnt = 5'(ALIGN_CYCLES);
    else if (align_cnt != 5'h00)
      next_align_cnt = align_cnt - 5'h01;
  end

  // registers, reset while powerdown is low
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= ST_IDLE;
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bitn <= 4'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      have_ptr <= 1'b0;
      sda_oe <= 1'b0;
      ptr <= 8'h00;
      page <= RST_PAGE;
      book <= RST_BOOK;
      modr <= RST_MODULATION;
      pwr <= RST_POWER_STATE;
      phs <= RST_PHASE_SYNC;
      strap <= 2'h0;
      strap_q <= 2'h0;
      aud_q1 <= 1'b0;
      aud_q2 <= 1'b0;
      clk_seen <= 1'b0;
      align_cnt <= 5'h00;
    end
    else
    begin
      st <= next_st;
      scl_s <= next_scl_s;
      sda_s <= next_sda_s;
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
      bitn <= next_bitn;
      sh <= next_sh;
      rd <= next_rd;
      have_ptr <= next_have_ptr;
      sda_oe <= next_sda_oe;
      ptr <= next_ptr;
      page <= next_page;
      book <= next_book;
      modr <= next_modr;
      pwr <= next_pwr;
      phs <= next_phs;
      strap_q <= addr_strap;
      strap <= next_strap;
      aud_q1 <= next_aud_q1;
      aud_q2 <= next_aud_q2;
      clk_seen <= next_clk_seen;
      align_cnt <= next_align_cnt;
    end
  end

  // decoded amplifier controls, registered
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      output_modulation_select <= MOD_IN_PHASE;
      analog_regulator_on <= 1'b0;
      outputs_hiz <= 1'b1;
      outputs_switching <= 1'b0;
      phase_sync_enable <= 1'b0;
      phase_select <= 2'h0;
      phase_aligning <= 1'b0;
      book_select <= RST_BOOK;
    end
    else
    begin
      output_modulation_select <= modr[1:0];
      analog_regulator_on <= (pwr[1:0] != PWR_DEEP_SLEEP);
      outputs_hiz <= (pwr[1:0] != PWR_PLAY) || (align_cnt != 5'h00);
      outputs_switching <= (pwr[1:0] == PWR_PLAY) && (align_cnt == 5'h00);
      phase_sync_enable <= (phs[1:0] == PHASE_ENABLE_VAL);
      phase_select <= phs[PHASE_SEL_LSB +: 2];
      phase_aligning <= (next_align_cnt != 5'h00);
      book_select <= book;
    end
  end

  assign bus.sda_s_oe = sda_oe;
endmodule

// ---- logic/acps_pkg.sv ----
// Purpose: shared constants for the amplifier control port (I2C slave and host master)
// Assumes: 10 MHz system clock on both ends
// Notes:   register offsets are byte addresses inside the current page
package acps_pkg;
  // slave address prefix
  localparam logic [4:0] ADDR_PREFIX      = 5'h0B;
  // register offsets
  localparam logic [7:0] REG_PAGE_SELECT  = 8'h00;
  localparam logic [7:0] REG_MODULATION   = 8'h02;
  localparam logic [7:0] REG_POWER_STATE  = 8'h03;
  localparam logic [7:0] REG_PHASE_SYNC   = 8'h6A;
  localparam logic [7:0] REG_BOOK_SELECT  = 8'h7F;
  // reset values
  localparam logic [7:0] RST_PAGE         = 8'h00;
  localparam logic [7:0] RST_BOOK         = 8'h00;
  localparam logic [7:0] RST_MODULATION   = 8'h00;
  localparam logic [7:0] RST_POWER_STATE  = 8'h00;
  localparam logic [7:0] RST_PHASE_SYNC   = 8'h00;
  // power state field encodings
  localparam logic [1:0] PWR_DEEP_SLEEP   = 2'h0;
  localparam logic [1:0] PWR_SLEEP        = 2'h1;
  localparam logic [1:0] PWR_HIZ          = 2'h2;
  localparam logic [1:0] PWR_PLAY         = 2'h3;
  // modulation field encodings
  localparam logic [1:0] MOD_IN_PHASE     = 2'h0;
  localparam logic [1:0] MOD_SINGLE_SIDE  = 2'h1;
  localparam logic [1:0] MOD_HYBRID       = 2'h2;
  // phase register: low two bits enable sync, bits 3:2 pick phase
  localparam logic [1:0] PHASE_ENABLE_VAL = 2'h3;
  localparam int         PHASE_SEL_LSB    = 2;
  localparam int         PHASE_STEP_DEG   = 45;
  // I2C timing, host side divider from 10 MHz
  localparam int         CLK_HZ           = 10000000;
  localparam int         I2C_STD_HZ       = 100000;
  localparam int         I2C_FAST_HZ      = 400000;
  localparam int         QTR_STD          = CLK_HZ / (4 * I2C_STD_HZ);
  localparam int         QTR_FAST         = CLK_HZ / (4 * I2C_FAST_HZ);
  // phase alignment sequence length in clock cycles
  localparam int         ALIGN_CYCLES     = 16;
endpackage

// ---- logic/acps_if.sv ----
// Purpose: two-wire bus joining host master and amplifier slave
// Assumes: open-drain wires, pull-up modelled by the AND of releases
// Notes:   an enable high means that end pulls the line low
interface acps_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-AND of the open-drain drivers
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave  (output sda_s_oe, input scl, input sda);
endinterface

// ---- logic/acps_host.sv ----
// Purpose: host I2C master issuing one register write or read per command
// Assumes: same clock as user logic; slave end on the shared bus
// Notes:   sequencing of pages and shutdown restore is the user's job
module acps_host
  import acps_pkg::*;
#(
  parameter int QTR = QTR_FAST
)
(
  // system
  input  wire logic       clock,
  input  wire logic       nrst,
  // bus
  acps_if.master          bus,
  // command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  // answer
  output logic            busy,
  output logic            done,
  output logic            nack,
  output logic      [7:0] rdata
);
  // bit script: each step is one bus bit or condition
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BITS  = 4'b0100,
    HS_STOP  = 4'b1000
  } acps_hs_t;

  acps_hs_t st, next_st;
  logic [7:0] q, next_q;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [1:0] seg, next_seg;
  logic [7:0] sh, next_sh;
  logic       scl_oe, sda_oe, next_scl_oe, next_sda_oe;
  logic       rd, next_rd, next_busy, next_done, next_nack;
  logic [7:0] rb, next_rb, next_rdata, rg, next_rg, wd, next_wd;
  logic [6:0] ad, next_ad;
  logic       sda_q1, sda_q2;

  always_comb
  begin
    next_st = st; next_q = q; next_ph = ph; next_bitn = bitn; next_seg = seg;
    next_sh = sh; next_scl_oe = scl_oe; next_sda_oe = sda_oe; next_rd = rd;
    next_busy = busy; next_done = 1'b0; next_nack = nack; next_rb = rb;
    next_rdata = rdata; next_rg = rg; next_wd = wd; next_ad = ad;
    if (st != HS_IDLE) next_q = (q == 8'(QTR - 1)) ? 8'h00 : q + 8'h01;
    case (st)
      HS_IDLE:
        if (cmd_valid)
        begin
          next_busy = 1'b1; next_nack = 1'b0; next_rd = cmd_read;
          next_ad = cmd_addr; next_rg = cmd_reg; next_wd = cmd_wdata;
          next_seg = 2'h0; next_sh = {cmd_addr, 1'b0}; next_st = HS_START;
          next_q = 8'h00; next_ph = 2'h0;
        end
      HS_START:
        if (q == 8'(QTR - 1))
        begin
          next_ph = ph + 2'h1;
          if (ph == 2'h0) next_sda_oe = 1'b0;
          if (ph == 2'h1) next_scl_oe = 1'b0;
          if (ph == 2'h2) next_sda_oe = 1'b1;                 // start / repeated start
          if (ph == 2'h3) begin next_scl_oe = 1'b1; next_bitn = 4'h0; next_st = HS_BITS; end
        end
      HS_BITS:
        if (q == 8'(QTR - 1))
        begin
          next_ph = ph + 2'h1;
          // ack slots and read data left to the slave; a single read ends in nack
          if (ph == 2'h0)
            next_sda_oe = (bitn == 4'h8) ? 1'b0 : ~sh[7] & ~(rd && seg == 2'h3);
          if (ph == 2'h1) next_scl_oe = 1'b0;
          if (ph == 2'h2)
          begin
            if (bitn == 4'h8 && !(rd && seg == 2'h3) && sda_q2) next_nack = 1'b1;
            if (bitn != 4'h8) next_rb = {rb[6:0], sda_q2};
          end
          if (ph == 2'h3)
          begin
            next_scl_oe = 1'b1;
            next_sh = {sh[6:0], 1'b0};
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h8)
            begin
              next_bitn = 4'h0;
              next_seg = seg + 2'h1;
              if (nack || (bitn == 4'h8 && next_nack)) next_st = HS_STOP;
              else if (seg == 2'h0) next_sh = rg;
              else if (seg == 2'h1 && rd)
              begin
                next_sh = {ad, 1'b1}; next_st = HS_START; next_sda_oe = 1'b0;
              end
              else if (seg == 2'h1) next_sh = wd;
              else if (seg == 2'h2 && rd) next_st = HS_BITS;      // read data byte follows
              else
              begin
                if (rd) next_rdata = rb;
                next_st = HS_STOP;                            // nack already sent on read
              end
            end
          end
        end
      HS_STOP:
        if (q == 8'(QTR - 1))
        begin
          next_ph = ph + 2'h1;
          if (ph == 2'h0) next_sda_oe = 1'b1;
          if (ph == 2'h1) next_scl_oe = 1'b0;
          if (ph == 2'h2) next_sda_oe = 1'b0;                 // stop
          if (ph == 2'h3) begin next_busy = 1'b0; next_done = 1'b1; next_st = HS_IDLE; end
        end
      default: next_st = HS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= HS_IDLE; q <= 8'h00; ph <= 2'h0; bitn <= 4'h0; seg <= 2'h0; sh <= 8'h00;
      scl_oe <= 1'b0; sda_oe <= 1'b0; rd <= 1'b0; busy <= 1'b0; done <= 1'b0;
      nack <= 1'b0; rb <= 8'h00; rdata <= 8'h00; rg <= 8'h00; wd <= 8'h00; ad <= 7'h00;
      sda_q1 <= 1'b1; sda_q2 <= 1'b1;
    end
    else
    begin
      st <= next_st; q <= next_q; ph <= next_ph; bitn <= next_bitn; seg <= next_seg;
      sh <= next_sh; scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; rd <= next_rd;
      busy <= next_busy; done <= next_done; nack <= next_nack; rb <= next_rb;
      rdata <= next_rdata; rg <= next_rg; wd <= next_wd; ad <= next_ad;
      sda_q1 <= bus.sda; sda_q2 <= sda_q1;
    end
  end

  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_oe = sda_oe;
endmodule

// ---- verif/acps_checker.sv ----
// Purpose: bus-level checks between host master and amplifier slave
// Assumes: one clock domain, bus levels registered by both ends
// Notes:   bit counter rebuilt from the wires; no knowledge of internals
module acps_checker
  import acps_pkg::*;
(
  // system
  input wire logic       clock,
  input wire logic       nrst,
  // bus drivers and levels
  input wire logic       scl_m_oe,
  input wire logic       sda_m_oe,
  input wire logic       sda_s_oe,
  input wire logic       scl,
  input wire logic       sda,
  // slave strap
  input wire logic [1:0] addr_strap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic       first;
  logic       rd;
  logic       hit;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic       start_ev;
  logic       stop_ev;
  logic       rise;
  logic       ack_slot;
  logic       addr_ok;
  // frame events seen on the wires
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise     = scl && !scl_q;
  assign ack_slot = rise && (bitn == 4'h8);
  assign addr_ok  = shreg[7:1] == {ADDR_PREFIX, addr_strap};
  // byte and frame tracking
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      first    <= 1'b0;
      rd       <= 1'b0;
      hit      <= 1'b0;
      bitn     <= 4'h0;
      shreg    <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev)
      begin
        in_frame <= 1'b1;
        first    <= 1'b1;
        rd       <= 1'b0;
        bitn     <= 4'h0;
      end
      else if (stop_ev)
      begin
        in_frame <= 1'b0;
        rd       <= 1'b0;
      end
      else if (rise && bitn == 4'h8)
      begin
        bitn  <= 4'h0;
        first <= 1'b0;
        if (first)
        begin
          hit <= addr_ok;
          rd  <= addr_ok && shreg[0];
        end
        else if (sda)
          rd <= 1'b0;
      end
      else if (rise)
      begin
        bitn  <= bitn + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  slave_edge_safe_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved sda while scl high");
  idle_release_a: assert property (!in_frame |-> !sda_s_oe)
    else $error("slave drives sda outside a frame");
  own_addr_ack_a: assert property (ack_slot && first && addr_ok |-> sda_s_oe)
    else $error("own address not acknowledged");
  foreign_quiet_a: assert property (ack_slot && first && !addr_ok |-> !sda_s_oe)
    else $error("foreign address acknowledged");
  reg_byte_ack_a: assert property (ack_slot && !first && hit && !rd |-> sda_s_oe)
    else $error("written byte not acknowledged");
  read_release_a: assert property (rise && rd && !first && bitn < 4'h8 |-> !sda_m_oe)
    else $error("master drives sda during read data");
  read_nack_a: assert property (ack_slot && rd && !first |-> !sda_m_oe && !sda_s_oe)
    else $error("single read not ended by nack");
  nack_stop_a: assert property (ack_slot && rd && !first |-> ##[1:60] stop_ev)
    else $error("no stop after read nack");
  cover property (ack_slot && first && !addr_ok);
  cover property (ack_slot && rd && !first);
  cover property (start_ev && in_frame);
endmodule

// ---- verif/acps_tb.sv ----
// Purpose: host and slave ends joined on one bus, driven from the host command side
// Assumes: 10 MHz clock, host quarter bit shortened to 3 cycles
// Notes:   multi-byte transfers are not issued by the host end
module acps_tb
  import acps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HQ = 3;
  logic       clock;
  logic       nrst;
  logic [1:0] addr_strap;
  logic       audio_clk_present;
  logic       cmd_valid;
  logic       cmd_read;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_wdata;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rdata;
  logic [1:0] mod_sel;
  logic       ana_on;
  logic       hiz;
  logic       sw;
  logic       ph_en;
  logic [1:0] ph_sel;
  logic       ph_al;
  logic [7:0] book;
  logic [7:0] rd_v;
  logic       nk_v;
  logic [6:0] dev;
  int         error_cnt;
  int         n_checks;
  assign dev = {ADDR_PREFIX, addr_strap};
  // the two ends and the wire checker
  acps_if bus_if ();
  acps_host #(.QTR(HQ)) u_acps_host (.clock(clock), .nrst(nrst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .busy(busy),
    .done(done), .nack(nack), .rdata(rdata));
  acps_slave u_acps_slave (.clock(clock), .nrst(nrst), .bus(bus_if), .addr_strap(addr_strap),
    .audio_clk_present(audio_clk_present), .output_modulation_select(mod_sel), .analog_regulator_on(ana_on),
    .outputs_hiz(hiz), .outputs_switching(sw), .phase_sync_enable(ph_en), .phase_select(ph_sel),
    .phase_aligning(ph_al), .book_select(book));
  acps_checker u_acps_checker (.clock(clock), .nrst(nrst), .scl_m_oe(bus_if.scl_m_oe),
    .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda),
    .addr_strap(addr_strap));
  // clock source
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic step;
    @(posedge clock);
    #10;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one host command, waits for its done pulse
  task automatic op(input logic r, input logic [6:0] a, input logic [7:0] g, input logic [7:0] w);
    int n;
    cmd_read  = r;
    cmd_addr  = a;
    cmd_reg   = g;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    step;
    cmd_valid = 1'b0;
    chk(8'(busy), 8'h01, "busy after command");
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      step;
      n++;
    end
    chk(8'(n < 3000), 8'h01, "done seen");
    chk(8'(busy), 8'h00, "idle with done");
    rd_v = rdata;
    nk_v = nack;
    step;
  endtask
  task automatic wr(input logic [7:0] g, input logic [7:0] w);
    op(1'b0, dev, g, w);
    chk(8'(nk_v), 8'h00, "write acked");
  endtask
  task automatic rdchk(input logic [7:0] g, input logic [7:0] exp, input string what);
    op(1'b1, dev, g, 8'h00);
    chk(rd_v, exp, what);
  endtask
  task automatic t_reset;
    chk(8'({bus_if.scl, bus_if.sda}), 8'h03, "bus idle high");
    chk(8'(hiz), 8'h01, "hiz after reset");
    chk(8'(ana_on), 8'h00, "regulator after reset");
    chk(book, RST_BOOK, "book after reset");
    rdchk(REG_PAGE_SELECT, RST_PAGE, "page reset");
    rdchk(REG_MODULATION, RST_MODULATION, "mod reset");
    rdchk(REG_POWER_STATE, RST_POWER_STATE, "state reset");
    rdchk(REG_PHASE_SYNC, RST_PHASE_SYNC, "phase reset");
    $display("test reset finished");
  endtask
  task automatic t_power;
    logic [1:0] sq [5];
    sq = '{PWR_DEEP_SLEEP, PWR_SLEEP, PWR_PLAY, PWR_HIZ, PWR_PLAY};
    foreach (sq[i])
    begin
      wr(REG_POWER_STATE, {6'h00, sq[i]});
      chk(8'(ana_on), 8'(sq[i] != PWR_DEEP_SLEEP), "regulator");
      chk(8'(hiz), 8'(sq[i] != PWR_PLAY), "hiz");
      chk(8'(sw), 8'(sq[i] == PWR_PLAY), "switching");
      rdchk(REG_POWER_STATE, {6'h00, sq[i]}, "state readback");
    end
    $display("test power finished");
  endtask
  task automatic t_mod;
    for (int m = 0; m < 3; m++)
    begin
      wr(REG_MODULATION, 8'(m));
      chk(8'(mod_sel), 8'(m), "modulation select");
      rdchk(REG_MODULATION, 8'(m), "mod readback");
    end
    $display("test modulation finished");
  endtask
  task automatic t_phase;
    int n;
    for (int p = 0; p < 4; p++)
    begin
      wr(REG_PHASE_SYNC, {4'h0, 2'(p), PHASE_ENABLE_VAL});
      chk(8'(ph_en), 8'h01, "sync enable");
      chk(8'(ph_sel), 8'(p), "phase select");
    end
    wr(REG_PHASE_SYNC, 8'h0E);
    chk(8'(ph_en), 8'h00, "sync off");
    // clocks halted, phase set, hiz, clocks back
    audio_clk_present = 1'b0;
    wr(REG_PHASE_SYNC, 8'h0B);
    wr(REG_POWER_STATE, {6'h00, PWR_HIZ});
    audio_clk_present = 1'b1;
    n = 0;
    while (ph_al !== 1'b1 && n < 10)
    begin
      step;
      n++;
    end
    chk(8'(ph_al), 8'h01, "aligning");
    chk(8'(hiz), 8'h01, "hiz while aligning");
    n = 0;
    while (ph_al === 1'b1 && n < 100)
    begin
      step;
      n++;
    end
    chk(8'(n), 8'(ALIGN_CYCLES), "align length");
    wr(REG_POWER_STATE, {6'h00, PWR_PLAY});
    chk(8'(sw), 8'h01, "play after align");
    $display("test phase finished");
  endtask
  task automatic t_page;
    wr(REG_PAGE_SELECT, 8'h05);
    rdchk(REG_PAGE_SELECT, 8'h05, "page number");
    wr(REG_MODULATION, 8'h01);
    rdchk(REG_MODULATION, 8'h00, "other page reads zero");
    wr(REG_BOOK_SELECT, 8'h8C);
    chk(book, 8'h00, "book held off page 0");
    wr(REG_PAGE_SELECT, 8'hFF);
    rdchk(REG_PAGE_SELECT, 8'hFF, "page 255");
    wr(REG_PAGE_SELECT, 8'h00);
    rdchk(REG_MODULATION, 8'h02, "page 0 untouched");
    wr(REG_BOOK_SELECT, 8'h8C);
    chk(book, 8'h8C, "book on page 0");
    $display("test page finished");
  endtask
  task automatic t_addr;
    for (int s = 0; s < 4; s++)
    begin
      addr_strap = 2'(s);
      step;
      step;
      op(1'b1, {ADDR_PREFIX, 2'(s)}, REG_MODULATION, 8'h00);
      chk(8'(nk_v), 8'h00, "own address");
      chk(rd_v, 8'h02, "read via strap");
      op(1'b0, {ADDR_PREFIX, ~2'(s)}, REG_MODULATION, 8'h01);
      chk(8'(nk_v), 8'h01, "other strap");
      op(1'b0, {5'h0A, 2'(s)}, REG_MODULATION, 8'h01);
      chk(8'(nk_v), 8'h01, "other prefix");
    end
    rdchk(REG_MODULATION, 8'h02, "no foreign write");
    $display("test address finished");
  endtask
  task automatic t_pdn;
    // power down in the middle of a transfer
    cmd_read  = 1'b0;
    cmd_reg   = REG_MODULATION;
    cmd_wdata = 8'h01;
    cmd_valid = 1'b1;
    step;
    cmd_valid = 1'b0;
    repeat (150) step;
    nrst = 1'b0;
    step;
    chk(8'(hiz), 8'h01, "hiz in shutdown");
    chk(book, RST_BOOK, "book in shutdown");
    nrst = 1'b1;
    step;
    rdchk(REG_MODULATION, RST_MODULATION, "mod after shutdown");
    rdchk(REG_PHASE_SYNC, RST_PHASE_SYNC, "phase after shutdown");
    wr(REG_MODULATION, {6'h00, MOD_SINGLE_SIDE});
    wr(REG_POWER_STATE, {6'h00, PWR_PLAY});
    chk(8'(mod_sel), 8'(MOD_SINGLE_SIDE), "restored mod");
    chk(8'(sw), 8'h01, "restored play");
    $display("test powerdown finished");
  endtask
  // hang guard
  initial
  begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    end_sim;
  end
  // main sequence
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    nrst = 1'b0;
    addr_strap = 2'h1;
    audio_clk_present = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    rd_v = 8'h00;
    nk_v = 1'b0;
    repeat (10) @(posedge clock);
    #10;
    nrst = 1'b1;
    step;
    t_reset;
    t_power;
    t_mod;
    t_phase;
    t_page;
    t_addr;
    t_pdn;
    end_sim;
  end
endmodule
